// ---- design/asp_pkg.sv ----
// Package: register map, field positions and reset values of the serial port
package asp_pkg;
	// ---------------------------------------------------------------
	// Register offsets (peripheral-file addresses)
	// ---------------------------------------------------------------
	localparam logic [15:0] OFS_CHAR_FORMAT = 16'h1050;
	localparam logic [15:0] OFS_PORT_CTRL = 16'h1051;
	localparam logic [15:0] OFS_DIV_HIGH = 16'h1052;
	localparam logic [15:0] OFS_DIV_LOW = 16'h1053;
	localparam logic [15:0] OFS_TX_STATUS = 16'h1054;
	localparam logic [15:0] OFS_RX_STATUS = 16'h1055;
	localparam logic [15:0] OFS_RX_HOLD = 16'h1057;
	localparam logic [15:0] OFS_TX_HOLD = 16'h1059;
	localparam logic [15:0] OFS_PIN_CTRL = 16'h105e;
	localparam logic [15:0] OFS_PRIO_TEST = 16'h105f;
	// ---------------------------------------------------------------
	// Field positions
	// ---------------------------------------------------------------
	localparam int FMT_STOP2 = 7;
	localparam int FMT_EVEN = 6;
	localparam int FMT_PAR_EN = 5;
	localparam int FMT_ASYNC_ON = 4;
	localparam int FMT_ADDR_MODE = 3;
	localparam int CTL_SOFT_RESET = 5;
	localparam int CTL_CLK_EN = 4;
	localparam int CTL_WAKE = 3;
	localparam int CTL_SLEEP = 2;
	localparam int CTL_TX_EN = 1;
	localparam int CTL_RX_EN = 0;
	// ---------------------------------------------------------------
	// Reset values and counts
	// ---------------------------------------------------------------
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [4:0] SAMPLES_PER_BIT = 5'h10;
	localparam logic [4:0] MID_SAMPLE = 5'h08;
	localparam logic [3:0] IDLE_BLOCK_BITS = 4'ha;
	localparam logic [3:0] WAKE_IDLE_BITS = 4'hb;
	localparam logic [7:0] PRIV_MASK = 8'hf0;
endpackage : asp_pkg

// ---- design/asp_serial_port.sv ----
// Asynchronous serial port: registers, bit-rate generator, transmitter, receiver
//
// Overview of operation
// - Bit rate is clock over 32 times divisor-plus-one
// - Divisor in two bytes, resets to zero
// - Bit 7 picks stop bits; receiver checks one
// - Bit 6 parity sense: 0 odd, 1 even
// - Bit 5 enables parity generation and checking
// - Address bit included in parity when enabled
// - Bit 4 low stops all communication
// - Bit 3 picks idle-line or address-bit scheme
// - Address-bit frames carry one extra bit
// - Wake request and sleep steer block handling
// - Bits 2..0 give length as code plus one
// - Short characters right-justified, zero-filled on receive
// - Privileged bits written only in privilege mode
// - Wake request copied to temporary on load, cleared
// - Ten idle bits mark a new block
// - Address bit one in first block frame only
// - Asleep receiver raises ready or errors only on address frames; break always
`timescale 1ns/1ps
module asp_serial_port #(
	parameter int ADDR_W = 16
) (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic rst_i,
	// Peripheral-file access
	input wire logic [ADDR_W-1:0] pf_addr_i,
	input wire logic pf_wr_i,
	input wire logic pf_rd_i,
	input wire logic [7:0] pf_wdata_i,
	input wire logic privilege_i,
	output logic [7:0] pf_rdata_o,
	// Serial lines
	input wire logic rx_line_i,
	output logic tx_line_o,
	// Interrupt requests (flag and enable)
	output logic tx_int_o,
	output logic rx_int_o
);
	// Elaboration check: the decoder compares sixteen address bits
	if (ADDR_W < 16) begin : g_addr_w_check
		$error("ADDR_W must be at least 16");
	end
	// ---------------------------------------------------------------
	// Registers
	// ---------------------------------------------------------------
	logic [7:0] char_format_control; // Format and mode
	logic [7:0] port_operation_control; // Enables and soft reset
	logic [7:0] rate_divisor_high; // Divisor high byte
	logic [7:0] rate_divisor_low; // Divisor low byte
	logic tx_int_en; // Transmit ready interrupt enable
	logic rx_int_en; // Receive interrupt enable
	logic [7:0] transmit_holding; // Transmit buffer
	logic [7:0] receive_holding; // Receive buffer
	logic [7:0] serial_pin_control; // Pin control, stored only
	logic [7:0] priority_and_test; // Priority and test bits
	logic tx_ready, tx_empty; // Transmit flags
	logic receive_ready_flag, address_frame_flag; // Receive flags
	logic brk_flag, fe_flag, oe_flag, pe_flag; // Error flags
	// ---------------------------------------------------------------
	// Decode
	// ---------------------------------------------------------------
	wire hit_fmt = pf_addr_i[15:0] == asp_pkg::OFS_CHAR_FORMAT;
	wire hit_ctl = pf_addr_i[15:0] == asp_pkg::OFS_PORT_CTRL;
	wire hit_dh = pf_addr_i[15:0] == asp_pkg::OFS_DIV_HIGH;
	wire hit_dl = pf_addr_i[15:0] == asp_pkg::OFS_DIV_LOW;
	wire hit_txs = pf_addr_i[15:0] == asp_pkg::OFS_TX_STATUS;
	wire hit_rxs = pf_addr_i[15:0] == asp_pkg::OFS_RX_STATUS;
	wire hit_rxb = pf_addr_i[15:0] == asp_pkg::OFS_RX_HOLD;
	wire hit_txb = pf_addr_i[15:0] == asp_pkg::OFS_TX_HOLD;
	wire hit_pin = pf_addr_i[15:0] == asp_pkg::OFS_PIN_CTRL;
	wire hit_pri = pf_addr_i[15:0] == asp_pkg::OFS_PRIO_TEST;
	wire wr_txb = pf_wr_i && hit_txb;
	wire rd_rxb = pf_rd_i && hit_rxb;
	// Port runs only with async on, clock on and soft reset released
	wire async_on = char_format_control[asp_pkg::FMT_ASYNC_ON];
	wire port_run = async_on
		&& port_operation_control[asp_pkg::CTL_CLK_EN]
		&& port_operation_control[asp_pkg::CTL_SOFT_RESET];
	wire soft_rst = !port_operation_control[asp_pkg::CTL_SOFT_RESET];
	wire addr_mode = char_format_control[asp_pkg::FMT_ADDR_MODE];
	wire par_en = char_format_control[asp_pkg::FMT_PAR_EN];
	wire par_even = char_format_control[asp_pkg::FMT_EVEN];
	wire stop2 = char_format_control[asp_pkg::FMT_STOP2];
	wire [3:0] char_len = {1'b0, char_format_control[2:0]} + 4'h1;
	wire sleep = port_operation_control[asp_pkg::CTL_SLEEP];
	wire wake_request = port_operation_control[asp_pkg::CTL_WAKE];
	wire [15:0] divisor = {rate_divisor_high, rate_divisor_low};
	wire rx_error = brk_flag | fe_flag | oe_flag | pe_flag;
	// Read multiplexer, unmapped reads return zero
	assign pf_rdata_o = hit_fmt ? char_format_control :
		hit_ctl ? {2'b00, port_operation_control[5:0]} :
		hit_dh ? rate_divisor_high :
		hit_dl ? rate_divisor_low :
		hit_txs ? {tx_ready, tx_empty, 5'b00000, tx_int_en} :
		hit_rxs ? {rx_error, receive_ready_flag, brk_flag, fe_flag,
			oe_flag, pe_flag, address_frame_flag, rx_int_en} :
		hit_rxb ? receive_holding :
		hit_txb ? transmit_holding :
		hit_pin ? serial_pin_control :
		hit_pri ? priority_and_test : asp_pkg::RST_BYTE;
	assign tx_int_o = tx_ready & tx_int_en;
	assign rx_int_o = (receive_ready_flag | brk_flag) & rx_int_en;
	// Parity over data and optional address bit
	function automatic logic par_bit(input logic [7:0] d, input logic [3:0] n,
		input logic ab, input logic inc_ab, input logic even);
		logic p;
		p = 1'b0;
		for (int i = 0; i < 8; i++) begin
			if (i < int'(n)) p = p ^ d[i];
		end
		if (inc_ab) p = p ^ ab;
		par_bit = even ? p : ~p;
	endfunction : par_bit
	// ---------------------------------------------------------------
	// Sample tick: 16 ticks per bit, bit = clk/(32*(div+1))
	// ---------------------------------------------------------------
	logic [15:0] div_cnt; // Divides clock by divisor+1
	logic div_half; // Toggles per divisor wrap
	wire tick = port_run && div_cnt == 16'h0000 && div_half;
	always_ff @(posedge core_clk_i) begin
		if (rst_i || !port_run) begin
			div_cnt <= 16'h0000;
			div_half <= 1'b0;
		end else if (div_cnt == 16'h0000) begin
			div_cnt <= divisor;
			div_half <= ~div_half;
		end else begin
			div_cnt <= div_cnt - 16'h0001;
		end
	end
	// ---------------------------------------------------------------
	// Register writes
	// ---------------------------------------------------------------
	logic tx_load; // Holding buffer moves into the shifter
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			char_format_control <= asp_pkg::RST_BYTE;
			port_operation_control <= asp_pkg::RST_BYTE;
			rate_divisor_high <= asp_pkg::RST_BYTE;
			rate_divisor_low <= asp_pkg::RST_BYTE;
			tx_int_en <= 1'b0;
			rx_int_en <= 1'b0;
			transmit_holding <= asp_pkg::RST_BYTE;
			serial_pin_control <= asp_pkg::RST_BYTE;
			priority_and_test <= asp_pkg::RST_BYTE;
		end else begin
			if (pf_wr_i && hit_fmt) char_format_control <= pf_wdata_i;
			if (pf_wr_i && hit_ctl) begin
				// Wake request is set-only from software
				port_operation_control <= {2'b00, pf_wdata_i[5:4],
					pf_wdata_i[3] | wake_request, pf_wdata_i[2:0]};
			end else if (tx_load) begin
				port_operation_control[asp_pkg::CTL_WAKE] <= 1'b0;
			end
			if (pf_wr_i && hit_dh) rate_divisor_high <= pf_wdata_i;
			if (pf_wr_i && hit_dl) rate_divisor_low <= pf_wdata_i;
			if (pf_wr_i && hit_txs) tx_int_en <= pf_wdata_i[0];
			if (pf_wr_i && hit_rxs) rx_int_en <= pf_wdata_i[0];
			if (wr_txb) transmit_holding <= pf_wdata_i;
			if (pf_wr_i && hit_pin) serial_pin_control <= pf_wdata_i;
			if (pf_wr_i && hit_pri && privilege_i) begin
				priority_and_test <= pf_wdata_i & asp_pkg::PRIV_MASK;
			end
		end
	end
	// ---------------------------------------------------------------
	// Transmitter
	// ---------------------------------------------------------------
	typedef enum logic [2:0] {
		TX_IDLE, TX_START, TX_DATA, TX_ADDR, TX_PAR, TX_STOP, TX_GAP
	} asp_tx_t;
	asp_tx_t tx_state;
	logic [7:0] transmit_shifter; // Shift register
	logic wake_temporary; // Wake copy for current frame
	logic [3:0] tx_sub; // Sample count within bit
	logic [3:0] tx_bits; // Bits sent in current phase
	wire tx_en = port_operation_control[asp_pkg::CTL_TX_EN];
	wire tx_bit_end = tick && tx_sub == 4'hf;
	// Last stop bit or last wake idle bit is ending
	wire tx_last_stop = tx_state == TX_STOP && tx_bit_end
		&& !(stop2 && tx_bits == 4'h0);
	wire tx_gap_done = tx_state == TX_GAP && tx_bit_end
		&& tx_bits == asp_pkg::WAKE_IDLE_BITS - 4'h1;
	// Frames start on a tick from idle or right after the previous one,
	// so a start bit never comes out shorter than one bit time
	wire tx_slot = (tx_state == TX_IDLE && tick) || tx_last_stop
		|| tx_gap_done;
	wire tx_gap_next = wake_request && !addr_mode; // Idle-line wake
	assign tx_load = port_run && tx_en && !tx_ready && tx_slot;
	always_ff @(posedge core_clk_i) begin
		if (rst_i || soft_rst) begin
			tx_state <= TX_IDLE;
			tx_line_o <= 1'b1;
			tx_ready <= 1'b1;
			tx_empty <= 1'b1;
			transmit_shifter <= asp_pkg::RST_BYTE;
			wake_temporary <= 1'b0;
			tx_sub <= 4'h0;
			tx_bits <= 4'h0;
		end else begin
			if (tick) tx_sub <= tx_sub + 4'h1;
			unique case (tx_state)
				TX_IDLE: begin
					tx_line_o <= 1'b1;
					tx_sub <= 4'h0;
					tx_bits <= 4'h0;
					if (tx_ready) tx_empty <= 1'b1;
				end
				TX_START: if (tx_bit_end) begin
					tx_state <= TX_DATA;
					tx_line_o <= transmit_shifter[0];
					tx_bits <= 4'h1;
				end
				TX_DATA: if (tx_bit_end) begin
					if (tx_bits == char_len) begin
						tx_bits <= 4'h0;
						if (addr_mode) begin
							tx_state <= TX_ADDR;
							tx_line_o <= wake_temporary;
						end else if (par_en) begin
							tx_state <= TX_PAR;
							tx_line_o <= par_bit(transmit_shifter, char_len,
								1'b0, 1'b0, par_even);
						end else begin
							tx_state <= TX_STOP;
							tx_line_o <= 1'b1;
						end
					end else begin
						tx_line_o <= transmit_shifter[tx_bits[2:0]];
						tx_bits <= tx_bits + 4'h1;
					end
				end
				TX_ADDR: if (tx_bit_end) begin
					tx_state <= par_en ? TX_PAR : TX_STOP;
					tx_line_o <= par_en ? par_bit(transmit_shifter, char_len,
						wake_temporary, 1'b1, par_even) : 1'b1;
				end
				TX_PAR: if (tx_bit_end) begin
					tx_state <= TX_STOP;
					tx_line_o <= 1'b1;
				end
				TX_STOP: if (tx_bit_end) begin
					tx_line_o <= 1'b1;
					if (stop2 && tx_bits == 4'h0) begin
						tx_bits <= 4'h1;
					end else begin
						tx_state <= TX_IDLE;
					end
				end
				TX_GAP: if (tx_bit_end) begin
					tx_line_o <= 1'b1;
					tx_bits <= tx_bits + 4'h1;
					if (tx_bits == asp_pkg::WAKE_IDLE_BITS - 4'h1) begin
						tx_state <= TX_IDLE;
					end
				end
			endcase
			// Load overrides the moves above; no idle bit between frames
			if (tx_load) begin
				transmit_shifter <= transmit_holding;
				wake_temporary <= wake_request;
				tx_ready <= 1'b1;
				tx_sub <= 4'h0;
				tx_bits <= 4'h0;
				// Idle-line wake sends an 11-bit idle instead
				tx_state <= tx_gap_next ? TX_GAP : TX_START;
				tx_line_o <= tx_gap_next;
			end
			// A write in the loading cycle keeps the buffer marked full
			if (wr_txb) begin
				tx_ready <= 1'b0;
				tx_empty <= 1'b0;
			end
		end
	end
	// ---------------------------------------------------------------
	// Receiver: three-stage synchroniser on the line
	// ---------------------------------------------------------------
	logic [2:0] rx_sync; // Stage 0 read only by stage 1
	logic rx_bit; // Filtered line level
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			rx_sync <= 3'b111;
			rx_bit <= 1'b1;
		end else begin
			rx_sync <= {rx_sync[1:0], rx_line_i};
			if (rx_sync[2] == rx_sync[1]) rx_bit <= rx_sync[2];
		end
	end
	typedef enum logic [2:0] {
		RX_IDLE, RX_START, RX_DATA, RX_ADDR, RX_PAR, RX_STOP, RX_BREAK
	} asp_rx_t;
	asp_rx_t rx_state;
	logic [7:0] rx_shift; // Assembled character
	logic [3:0] rx_sub; // Sample count within bit
	logic [3:0] rx_bits; // Data bits taken
	logic [3:0] idle_bits; // Idle bit times since last frame
	logic rx_addr_bit; // Received address bit
	logic rx_par_ok; // Parity check result
	wire rx_mid = tick && rx_sub == asp_pkg::MID_SAMPLE[3:0];
	wire block_start = idle_bits >= asp_pkg::IDLE_BLOCK_BITS;
	wire is_addr = addr_mode ? rx_addr_bit : block_start;
	wire rx_en = port_operation_control[asp_pkg::CTL_RX_EN];
	always_ff @(posedge core_clk_i) begin
		if (rst_i || soft_rst) begin
			rx_state <= RX_IDLE;
			rx_shift <= asp_pkg::RST_BYTE;
			receive_holding <= asp_pkg::RST_BYTE;
			rx_sub <= 4'h0;
			rx_bits <= 4'h0;
			idle_bits <= 4'h0;
			rx_addr_bit <= 1'b0;
			rx_par_ok <= 1'b1;
			receive_ready_flag <= 1'b0;
			address_frame_flag <= 1'b0;
			brk_flag <= 1'b0;
			fe_flag <= 1'b0;
			oe_flag <= 1'b0;
			pe_flag <= 1'b0;
		end else begin
			// Reading the buffer clears flags; a same-cycle set wins below
			if (rd_rxb) begin
				receive_ready_flag <= 1'b0;
				fe_flag <= 1'b0;
				oe_flag <= 1'b0;
				pe_flag <= 1'b0;
			end
			if (tick) rx_sub <= rx_sub + 4'h1;
			unique case (rx_state)
				RX_IDLE: begin
					if (tick && rx_sub == 4'hf && !block_start) begin
						idle_bits <= idle_bits + 4'h1;
					end
					if (port_run && !rx_bit) begin
						rx_state <= RX_START;
						rx_sub <= 4'h0;
					end
				end
				RX_START: if (rx_mid) begin
					rx_state <= rx_bit ? RX_IDLE : RX_DATA;
					rx_bits <= 4'h0;
					rx_shift <= asp_pkg::RST_BYTE;
					rx_sub <= asp_pkg::MID_SAMPLE[3:0] + 4'h1;
				end
				RX_DATA: if (rx_mid) begin
					rx_shift[rx_bits[2:0]] <= rx_bit;
					rx_bits <= rx_bits + 4'h1;
					if (rx_bits + 4'h1 == char_len) begin
						rx_state <= addr_mode ? RX_ADDR :
							par_en ? RX_PAR : RX_STOP;
					end
				end
				RX_ADDR: if (rx_mid) begin
					rx_addr_bit <= rx_bit;
					rx_state <= par_en ? RX_PAR : RX_STOP;
				end
				RX_PAR: if (rx_mid) begin
					rx_par_ok <= rx_bit == par_bit(rx_shift, char_len,
						rx_addr_bit, addr_mode, par_even);
					rx_state <= RX_STOP;
				end
				RX_STOP: if (rx_mid) begin
					// Only one stop bit is checked
					rx_state <= rx_bit ? RX_IDLE : RX_BREAK;
					idle_bits <= 4'h0;
					if (!sleep || is_addr) begin
						if (rx_en) begin
							receive_holding <= rx_shift;
							receive_ready_flag <= 1'b1;
							oe_flag <= receive_ready_flag & !rd_rxb;
						end
						address_frame_flag <= is_addr;
						fe_flag <= !rx_bit;
						pe_flag <= par_en && !rx_par_ok;
					end
					rx_par_ok <= 1'b1;
					rx_addr_bit <= 1'b0;
				end
				RX_BREAK: begin
					// Line low ten bit times after a missing stop
					if (rx_bit) begin
						rx_state <= RX_IDLE;
					end else if (tick && rx_sub == 4'hf) begin
						idle_bits <= idle_bits + 4'h1;
						if (idle_bits == asp_pkg::IDLE_BLOCK_BITS - 4'h1) begin
							brk_flag <= 1'b1;
						end
					end
				end
			endcase
		end
	end
endmodule : asp_serial_port

// ---- verification/asp_serial_port_monitor.sv ----
// Checker of the serial port's register and line behaviour
`timescale 1ns/1ps
module asp_serial_port_monitor #(
	parameter int ADDR_W = 16
) (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic rst_i,
	// Register access
	input wire logic [ADDR_W-1:0] pf_addr_i,
	input wire logic pf_wr_i,
	input wire logic pf_rd_i,
	input wire logic [7:0] pf_wdata_i,
	input wire logic privilege_i,
	input wire logic [7:0] pf_rdata_o,
	// Serial lines and requests
	input wire logic rx_line_i,
	input wire logic tx_line_o,
	input wire logic tx_int_o,
	input wire logic rx_int_o
);
	logic [7:0] fmt_q; // Shadow of the format register
	logic tx_prev; // Line level one cycle back
	logic [15:0] run_len; // Cycles since the line last moved
	wire fmt_wr = pf_wr_i && pf_addr_i == asp_pkg::OFS_CHAR_FORMAT;
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (rst_i);
	// Follow format writes
	always_ff @(posedge core_clk_i) begin
		if (rst_i) fmt_q <= asp_pkg::RST_BYTE;
		else if (fmt_wr) fmt_q <= pf_wdata_i;
	end
	// Measure how long the line holds each level, saturating
	always_ff @(posedge core_clk_i) begin
		tx_prev <= tx_line_o;
		if (rst_i) run_len <= 16'hffff;
		else if (tx_line_o != tx_prev) run_len <= 16'h0000;
		else if (run_len != 16'hffff) run_len <= run_len + 16'h0001;
	end
	a_reset_idle: assert property (
		$fell(rst_i) |-> tx_line_o && !tx_int_o && !rx_int_o)
		else $error("line or request wrong after reset");
	a_div_low_rw: assert property (
		pf_wr_i && pf_addr_i == asp_pkg::OFS_DIV_LOW ##1
		pf_addr_i == asp_pkg::OFS_DIV_LOW |-> pf_rdata_o == $past(pf_wdata_i))
		else $error("low divisor byte not written");
	a_div_high_rw: assert property (
		pf_wr_i && pf_addr_i == asp_pkg::OFS_DIV_HIGH ##1
		pf_addr_i == asp_pkg::OFS_DIV_HIGH |-> pf_rdata_o == $past(pf_wdata_i))
		else $error("high divisor byte not written");
	a_priv_refused: assert property (
		pf_wr_i && !privilege_i && pf_addr_i == asp_pkg::OFS_PRIO_TEST ##1
		pf_addr_i == asp_pkg::OFS_PRIO_TEST |-> $stable(pf_rdata_o))
		else $error("privileged bits changed outside privilege");
	a_priv_low_zero: assert property (
		pf_addr_i == asp_pkg::OFS_PRIO_TEST |-> pf_rdata_o[3:0] == 4'h0)
		else $error("unprivileged bits of priority register not zero");
	a_bit_min_len: assert property (
		tx_line_o != tx_prev |-> run_len >= 16'h001f)
		else $error("transmit level held under one bit time");
	a_rx_upper_zero: assert property (
		pf_addr_i == asp_pkg::OFS_RX_HOLD |->
		(pf_rdata_o >> ({1'b0, fmt_q[2:0]} + 4'h1)) == 8'h00)
		else $error("received character not zero padded");
	a_async_quiet: assert property (
		!fmt_q[4] && tx_line_o ##1 !fmt_q[4] |-> tx_line_o)
		else $error("line moved with asynchronous mode off");
endmodule : asp_serial_port_monitor

bind asp_serial_port asp_serial_port_monitor #(.ADDR_W(ADDR_W)) i_mon (
	.core_clk_i(core_clk_i), .rst_i(rst_i), .pf_addr_i(pf_addr_i),
	.pf_wr_i(pf_wr_i), .pf_rd_i(pf_rd_i), .pf_wdata_i(pf_wdata_i),
	.privilege_i(privilege_i), .pf_rdata_o(pf_rdata_o),
	.rx_line_i(rx_line_i), .tx_line_o(tx_line_o),
	.tx_int_o(tx_int_o), .rx_int_o(rx_int_o));

// ---- verification/asp_remote_term.sv ----
// Remote terminal model: sends frames to the port, captures its frames
`timescale 1ns/1ps
module asp_remote_term (
	// Clock that times bit periods
	input wire logic core_clk_i,
	// Serial lines seen from the far side
	input wire logic tx_line_i,
	output logic rx_line_o
);
	longint now; // Cycle count for frame timing
	initial begin
		rx_line_o = 1'b1;
		now = 0;
	end
	always @(posedge core_clk_i) now <= now + 1;
	// Start bit, payload LSB first, one stop; the line then rests high
	task automatic send(input logic [11:0] v, input int k, input int bt);
		for (int i = -1; i <= k; i++) begin
			@(negedge core_clk_i);
			rx_line_o = (i < 0) ? 1'b0 : (i == k) ? 1'b1 : v[i];
			repeat (bt - 1) @(negedge core_clk_i);
		end
	endtask : send
	// Wait for a start edge, then sample each bit at its centre
	task automatic grab(output logic [11:0] v, output longint t0,
		input int k, input int bt);
		int w;
		v = 12'h000;
		w = 0;
		while (tx_line_i !== 1'b0 && w < 4000) begin
			@(negedge core_clk_i);
			w++;
		end
		t0 = now;
		repeat (bt / 2) @(negedge core_clk_i);
		for (int i = 0; i <= k; i++) begin
			repeat (bt) @(negedge core_clk_i);
			v[i] = tx_line_i;
		end
	endtask : grab
endmodule : asp_remote_term

// ---- verification/testbench.sv ----
// Self-checking bench: serial port against a remote terminal model
`timescale 1ns/1ps
module testbench;
	// ---------------------------------------------------------------
	// Design pins and bench counters
	// ---------------------------------------------------------------
	logic core_clk_i; // 20 MHz clock
	logic rst_i; // Synchronous reset
	logic [15:0] pf_addr_i; // Register address
	logic pf_wr_i; // Write strobe
	logic pf_rd_i; // Read strobe
	logic [7:0] pf_wdata_i; // Write data
	logic privilege_i; // Privilege mode
	logic [7:0] pf_rdata_o; // Read data
	logic rx_line; // Terminal to port
	logic tx_line; // Port to terminal
	logic tx_int_o; // Transmit request
	logic rx_int_o; // Receive request
	int n_mismatch = 0; // Failed comparisons
	int total_checks = 0; // All comparisons
	int cyc = 0; // Cycles run
	asp_serial_port i_asp_serial_port (.core_clk_i(core_clk_i),
		.rst_i(rst_i), .pf_addr_i(pf_addr_i), .pf_wr_i(pf_wr_i),
		.pf_rd_i(pf_rd_i), .pf_wdata_i(pf_wdata_i),
		.privilege_i(privilege_i), .pf_rdata_o(pf_rdata_o),
		.rx_line_i(rx_line), .tx_line_o(tx_line),
		.tx_int_o(tx_int_o), .rx_int_o(rx_int_o));
	asp_remote_term i_asp_remote_term (.core_clk_i(core_clk_i),
		.tx_line_i(tx_line), .rx_line_o(rx_line));
	// 50 ns clock
	initial begin
		core_clk_i = 1'b0;
		forever #25 core_clk_i = ~core_clk_i;
	end
	// Cut a hang short
	always @(posedge core_clk_i) begin
		cyc++;
		if (cyc == 90000) begin
			n_mismatch++;
			test_done();
		end
	end
	// Verdict and end of run
	task automatic test_done;
		if (n_mismatch == 0 && total_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : test_done
	// Compare and report
	task automatic cmp(input logic [15:0] g, input logic [15:0] e);
		total_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
		end
	endtask : cmp
	// One-cycle register write
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(negedge core_clk_i);
		pf_addr_i = a;
		pf_wdata_i = d;
		pf_wr_i = 1'b1;
		@(negedge core_clk_i);
		pf_wr_i = 1'b0;
	endtask : wr
	// One-cycle register read
	task automatic rd(input logic [15:0] a, output logic [7:0] d);
		@(negedge core_clk_i);
		pf_addr_i = a;
		pf_rd_i = 1'b1;
		@(posedge core_clk_i);
		d = pf_rdata_o;
		@(negedge core_clk_i);
		pf_rd_i = 1'b0;
	endtask : rd
	task automatic chk(input logic [15:0] a, input logic [7:0] e);
		logic [7:0] d;
		rd(a, d);
		cmp(d, e);
	endtask : chk
	// Poll a status register until a masked flag shows, bounded
	task automatic wait_flag(input logic [15:0] a, input logic [7:0] m);
		logic [7:0] s;
		int n;
		s = 8'h00;
		n = 0;
		while ((s & m) == 8'h00 && n < 3000) begin
			rd(a, s);
			n++;
		end
		cmp(16'((s & m) != 8'h00), 16'h0001);
	endtask : wait_flag
	// Expected payload: data LSB first, address bit, parity
	function automatic int frame(input logic [7:0] f, input logic [7:0] d,
		input logic w, output logic [11:0] v);
		int k;
		v = 12'h000;
		k = 0;
		for (int i = 0; i <= int'(f[2:0]); i++) begin
			v[k] = d[i];
			k++;
		end
		if (f[3]) begin
			v[k] = w;
			k++;
		end
		if (f[5]) begin
			v[k] = ^v ^ ~f[6];
			k++;
		end
		return k;
	endfunction : frame
	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial begin
		logic [7:0] f;
		logic [7:0] d;
		logic [7:0] s;
		logic [11:0] v1;
		logic [11:0] v2;
		logic [11:0] e;
		longint t1;
		longint t2;
		int k;
		int bt;
		int b;
		int x;
		logic bad;
		logic ien;
		rst_i = 1'b1;
		pf_addr_i = 16'h1050;
		pf_wr_i = 1'b0;
		pf_rd_i = 1'b0;
		pf_wdata_i = 8'h00;
		privilege_i = 1'b0;
		void'($urandom(89));
		repeat (20) @(negedge core_clk_i);
		rst_i = 1'b0;
		// Reset values, unmapped places 1056 and 1058 included
		for (int i = 0; i < 9; i++) begin
			chk(16'h1050 + 16'(i), (i == 4) ? 8'hc0 : 8'h00);
		end
		wr(16'h105f, 8'hff);
		chk(16'h105f, 8'h00);
		privilege_i = 1'b1;
		wr(16'h105f, 8'hff);
		chk(16'h105f, 8'hf0);
		privilege_i = 1'b0;
		d = 8'($urandom);
		wr(16'h1052, d);
		chk(16'h1052, d);
		wr(16'h1052, 8'h00);
		for (int t = 0; t < 8; t++) begin
			f = (t == 0) ? 8'hf8 : (t == 1) ? 8'h57 : 8'($urandom) | 8'h10;
			b = $urandom_range(3, 0);
			bt = 32 * (b + 1);
			d = 8'($urandom);
			wr(16'h1051, 8'h00);
			wr(16'h1053, 8'(b));
			wr(16'h1050, f);
			chk(16'h1050, f);
			wr(16'h1051, f[3] ? 8'h3b : 8'h33);
			k = frame(f, d, f[3], e);
			// Two characters back to back, first one an address
			fork
				begin
					i_asp_remote_term.grab(v1, t1, k, bt);
					i_asp_remote_term.grab(v2, t2, k, bt);
				end
				begin
					wr(16'h1059, d);
					wait_flag(16'h1054, 8'h80);
					wr(16'h1059, ~d);
				end
			join
			cmp(v1, e | (12'h001 << k));
			void'(frame(f, ~d, 1'b0, e));
			cmp(v2, e | (12'h001 << k));
			x = int'(t2 - t1) - (k + 2 + int'(f[7])) * bt;
			cmp(x >= -4 && x <= 4, 1'b1);
			chk(16'h1051, 8'h33);
			// Receive, with a spoiled parity bit on odd trials that have parity enabled
			bad = f[5] & t[0];
			ien = 1'($urandom);
			wr(16'h1051, 8'h37);
			wr(16'h1055, {7'h00, ien});
			wr(16'h1054, {7'h00, ien});
			k = frame(f, d, 1'b1, e);
			// Asleep: in address-bit mode a data frame is ignored; a block start is taken
			if (f[3]) begin
				void'(frame(f, ~d, 1'b0, v1));
				i_asp_remote_term.send(v1, k, bt);
				chk(16'h1055, {7'h00, ien});
			end else begin
				repeat (11 * bt) @(negedge core_clk_i);
			end
			i_asp_remote_term.send(e ^ (12'(bad) << (k - 1)), k, bt);
			wait_flag(16'h1055, 8'hc0);
			rd(16'h1055, s);
			cmp(s & 8'h86, bad ? 8'h86 : 8'h02);
			if (!bad) cmp(rx_int_o, ien);
			cmp(tx_int_o, ien);
			rd(16'h1057, s);
			if (!bad) cmp(s, d & ~(8'hff << (f[2:0] + 1)));
		end
		// Asynchronous mode off: a loaded character never leaves
		wr(16'h1051, 8'h00);
		wr(16'h1050, 8'h07);
		wr(16'h1051, 8'h33);
		wr(16'h1059, 8'h00);
		repeat (100) @(negedge core_clk_i);
		cmp(tx_line, 1'b1);
		test_done();
	end
endmodule : testbench
